/* inc/sdes_regs.svh */
// Purpose: Register numbers, field positions, reset values and codes for drop-event status.
// Assumes: Registers are reached by their register number on a simple strobe port.
// Notes:   Definitions only.
`ifndef SDES_REGS_SVH
`define SDES_REGS_SVH

`define SDES_REG_NUM_W        16
`define SDES_OFS_IMASK        16'h1880
`define SDES_OFS_STATUS       16'h1881

`define SDES_IMASK_BIT        0
`define SDES_IMASK_RESET      1'h1

`define SDES_PEND_BIT         0
`define SDES_A_VALID_BIT      1
`define SDES_A_PORT_LSB       2
`define SDES_A_REASON_LSB     4
`define SDES_B_VALID_BIT      8
`define SDES_B_PORT_LSB       9
`define SDES_B_REASON_LSB     11
`define SDES_USED_MSB         14

`define SDES_PORT_RESERVED    2'h3

`define SDES_RSN_UNTAGGED     4'h0
`define SDES_RSN_MISS_SRC_NM  4'h1
`define SDES_RSN_SRC_NOFWD    4'h2
`define SDES_RSN_DST_NOFWD    4'h3
`define SDES_RSN_DST_NM       4'h4
`define SDES_RSN_SRC_NM       4'h5
`define SDES_RSN_UNK_UCAST    4'h6
`define SDES_RSN_UNK_MCAST    4'h7
`define SDES_RSN_BCAST_LIMIT  4'h8
`define SDES_RSN_MISS_NOFWD   4'h9
`define SDES_RSN_SAME_PORT    4'hA
`define SDES_RSN_FILTERED     4'hB
`define SDES_RSN_VID_ONES     4'hE

`endif

/* inc/sdes_pkg.sv */
// Purpose: Types shared by the drop-event status logic.
// Assumes: Codes come from sdes_regs.svh.
// Notes:   None.
`include "sdes_regs.svh"
package sdes_pkg;
   typedef logic [3:0] sdes_reason_t;
   typedef logic [1:0] sdes_port_t;
   typedef logic [`SDES_REG_NUM_W-1:0] sdes_reg_num_t;
endpackage

/* src/sdes_reason_enc.sv */
// Purpose: Classifies one forwarding decision into a drop flag and a drop reason code.
// Assumes: Condition inputs are valid in the cycle of check_valid.
// Notes:   Fixed priority; the first matching cause is reported.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_regs.svh"
module sdes_reason_enc
   import sdes_pkg::*;
(
   input  wire logic                 check_valid,      // One decision to classify
   input  wire logic                 tagged_only_admission, // Only tagged frames admitted
   input  wire logic                 pkt_untagged,     // Untagged or priority tagged
   input  wire logic                 vid_all_ones,     // VLAN id is all ones
   input  wire logic                 bcast_over_limit, // Broadcast over throttle limit
   input  wire logic                 da_hit,           // Destination in lookup table
   input  wire logic                 da_unicast,       // Destination is unicast
   input  wire logic                 da_multicast,     // Destination is multicast
   input  wire logic                 member_check,     // Ingress membership checking on
   input  wire logic                 admit_non_member, // Non-member admission on
   input  wire logic                 src_member,       // Source port in incoming VLAN
   input  wire logic                 dst_member,       // Destination port in incoming VLAN
   input  wire logic                 src_forwarding,   // Source port forwarding
   input  wire logic                 dst_forwarding,   // Destination port forwarding
   input  wire logic                 drop_unknown,     // Unknown unicast discard on
   input  wire logic                 filter_multicast, // Unknown multicast filter on
   input  wire logic                 same_port,        // Source equals destination
   input  wire logic                 entry_filter,     // Table entry filter flag
   output logic                      drop,             // Decision is a drop
   output sdes_pkg::sdes_reason_t    reason            // Drop reason code
);
   import sdes_pkg::*;

   always_comb begin
      drop   = check_valid;
      reason = `SDES_RSN_UNTAGGED;
      if (vid_all_ones) begin
         reason = `SDES_RSN_VID_ONES;
      end else if (tagged_only_admission && pkt_untagged) begin
         reason = `SDES_RSN_UNTAGGED;
      end else if (bcast_over_limit) begin
         reason = `SDES_RSN_BCAST_LIMIT;
      end else if (!da_hit) begin
         if (!src_forwarding) begin
            reason = `SDES_RSN_MISS_NOFWD;
         end else if (member_check && !admit_non_member && !src_member) begin
            reason = `SDES_RSN_MISS_SRC_NM;
         end else if (drop_unknown && da_unicast) begin
            reason = `SDES_RSN_UNK_UCAST;
         end else if (filter_multicast && da_multicast) begin
            reason = `SDES_RSN_UNK_MCAST;
         end else begin
            drop = 1'b0;
         end
      end else if (!src_forwarding) begin
         reason = `SDES_RSN_SRC_NOFWD;
      end else if (!dst_forwarding) begin
         reason = `SDES_RSN_DST_NOFWD;
      end else if (member_check && !dst_member) begin
         reason = `SDES_RSN_DST_NM;
      end else if (member_check && !admit_non_member && !src_member) begin
         reason = `SDES_RSN_SRC_NM;
      end else if (same_port) begin
         reason = `SDES_RSN_SAME_PORT;
      end else if (entry_filter) begin
         reason = `SDES_RSN_FILTERED;
      end else begin
         drop = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* src/sdes_status.sv */
// Purpose: Drop-event status register with two records, pending flag and engine mask.
// Assumes: Register port strobes are one-cycle pulses synchronous to clk.
// Notes:   Read data is registered and returned one cycle after the read strobe.
//
// Behaviour
// - Two drop records held for software at once.
// - Engine mask gates every source onto interrupt.
// - Mask resets set; gates output, not status.
// - Untagged under tagged-only admission gives 0000.
// - Miss, non-member source, checks on gives 0001.
// - Hit: source 0010, destination 0011 not forwarding.
// - Hit: destination 0100, source 0101 not member.
// - Unknown unicast 0110, unknown multicast 0111.
// - Broadcast over throttle limit gives 1000.
// - Miss with source not forwarding gives 1001.
// - Hit: same port 1010, filter flag 1011.
// - All-ones VLAN identifier gives 1110.
// - Port field two bits, A 3:2, B 10:9.
// - B valid only with captured B fields.
// - A valid only with captured A fields.
// - Record A uses record B's reason codes.
// - Pending on any drop not from the reserved port; all clear on read.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_regs.svh"
module sdes_status
   import sdes_pkg::*;
(
   input  wire logic                 clk,              // Switch core clock
   input  wire logic                 nrst,             // Asynchronous reset, active low
   input  wire logic                 reg_rd,           // Register read strobe
   input  wire logic                 reg_wr,           // Register write strobe
   input  wire sdes_pkg::sdes_reg_num_t reg_num,       // Register number
   input  wire logic [31:0]          reg_wdata,        // Write data
   output logic [31:0]               reg_rdata,        // Read data, registered
   output logic                      reg_rack,         // Read data valid pulse
   input  wire logic                 check_valid,      // One forwarding decision
   input  wire sdes_pkg::sdes_port_t src_port,         // Ingress port of the decision
   input  wire logic                 tagged_only_admission, // Only tagged frames admitted
   input  wire logic                 pkt_untagged,     // Untagged or priority tagged
   input  wire logic                 vid_all_ones,     // VLAN id is all ones
   input  wire logic                 bcast_over_limit, // Broadcast over throttle limit
   input  wire logic                 da_hit,           // Destination in lookup table
   input  wire logic                 da_unicast,       // Destination is unicast
   input  wire logic                 da_multicast,     // Destination is multicast
   input  wire logic                 member_check,     // Ingress membership checking on
   input  wire logic                 admit_non_member, // Non-member admission on
   input  wire logic                 src_member,       // Source port in incoming VLAN
   input  wire logic                 dst_member,       // Destination port in incoming VLAN
   input  wire logic                 src_forwarding,   // Source port forwarding
   input  wire logic                 dst_forwarding,   // Destination port forwarding
   input  wire logic                 drop_unknown,     // Unknown unicast discard on
   input  wire logic                 filter_multicast, // Unknown multicast filter on
   input  wire logic                 same_port,        // Source equals destination
   input  wire logic                 entry_filter,     // Table entry filter flag
   output logic                      drop_irq          // Engine interrupt, active high
);
   import sdes_pkg::*;

   logic         drop;
   sdes_reason_t reason;
   logic         event_ok;
   logic         stat_rd;

   logic         pend_q,   pend_d;
   logic         a_vld_q,  a_vld_d;
   sdes_port_t   a_port_q, a_port_d;
   sdes_reason_t a_rsn_q,  a_rsn_d;
   logic         b_vld_q,  b_vld_d;
   sdes_port_t   b_port_q, b_port_d;
   sdes_reason_t b_rsn_q,  b_rsn_d;
   logic         mask_q,   mask_d;
   logic [31:0]  rdata_q,  rdata_d;
   logic         rack_q,   rack_d;
   logic [31:0]  status_word;

   sdes_reason_enc u_enc (
      .check_valid           (check_valid),
      .tagged_only_admission (tagged_only_admission),
      .pkt_untagged          (pkt_untagged),
      .vid_all_ones          (vid_all_ones),
      .bcast_over_limit      (bcast_over_limit),
      .da_hit                (da_hit),
      .da_unicast            (da_unicast),
      .da_multicast          (da_multicast),
      .member_check          (member_check),
      .admit_non_member      (admit_non_member),
      .src_member            (src_member),
      .dst_member            (dst_member),
      .src_forwarding        (src_forwarding),
      .dst_forwarding        (dst_forwarding),
      .drop_unknown          (drop_unknown),
      .filter_multicast      (filter_multicast),
      .same_port             (same_port),
      .entry_filter          (entry_filter),
      .drop                  (drop),
      .reason                (reason)
   );

   // A decision from the reserved port code is discarded whole, so no record can carry it.
   assign event_ok = drop && (src_port != `SDES_PORT_RESERVED);
   assign stat_rd  = reg_rd && (reg_num == `SDES_OFS_STATUS);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SDES_PEND_BIT]                        = pend_q;
      status_word[`SDES_A_VALID_BIT]                     = a_vld_q;
      status_word[`SDES_A_PORT_LSB +: 2]                 = a_port_q;
      status_word[`SDES_A_REASON_LSB +: 4]               = a_rsn_q;
      status_word[`SDES_B_VALID_BIT]                     = b_vld_q;
      status_word[`SDES_B_PORT_LSB +: 2]                 = b_port_q;
      status_word[`SDES_B_REASON_LSB +: 4]               = b_rsn_q;
   end

   // A read clears first and a same-cycle drop is then applied, so the set wins over the clear.
   always_comb begin
      pend_d   = pend_q;
      a_vld_d  = a_vld_q;
      a_port_d = a_port_q;
      a_rsn_d  = a_rsn_q;
      b_vld_d  = b_vld_q;
      b_port_d = b_port_q;
      b_rsn_d  = b_rsn_q;
      if (stat_rd) begin
         pend_d   = 1'b0;
         a_vld_d  = 1'b0;
         a_port_d = 2'h0;
         a_rsn_d  = 4'h0;
         b_vld_d  = 1'b0;
         b_port_d = 2'h0;
         b_rsn_d  = 4'h0;
      end
      if (event_ok) begin
         pend_d = 1'b1;
         if (!a_vld_d) begin
            a_vld_d  = 1'b1;
            a_port_d = src_port;
            a_rsn_d  = reason;
         end else if (!b_vld_d) begin
            b_vld_d  = 1'b1;
            b_port_d = src_port;
            b_rsn_d  = reason;
         end
      end
   end

   always_comb begin
      mask_d = mask_q;
      if (reg_wr && (reg_num == `SDES_OFS_IMASK)) begin
         mask_d = reg_wdata[`SDES_IMASK_BIT];
      end
      rack_d  = reg_rd;
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_num)
            `SDES_OFS_IMASK: begin
               rdata_d[`SDES_IMASK_BIT] = mask_q;
            end
            `SDES_OFS_STATUS: begin
               rdata_d = status_word;
            end
            default: begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_q   <= 1'b0;
         a_vld_q  <= 1'b0;
         a_port_q <= 2'h0;
         a_rsn_q  <= 4'h0;
         b_vld_q  <= 1'b0;
         b_port_q <= 2'h0;
         b_rsn_q  <= 4'h0;
         mask_q   <= `SDES_IMASK_RESET;
         rdata_q  <= 32'h0000_0000;
         rack_q   <= 1'b0;
      end else begin
         pend_q   <= pend_d;
         a_vld_q  <= a_vld_d;
         a_port_q <= a_port_d;
         a_rsn_q  <= a_rsn_d;
         b_vld_q  <= b_vld_d;
         b_port_q <= b_port_d;
         b_rsn_q  <= b_rsn_d;
         mask_q   <= mask_d;
         rdata_q  <= rdata_d;
         rack_q   <= rack_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rack  = rack_q;
   // The mask only gates the output; captured status keeps accumulating underneath.
   assign drop_irq  = pend_q && !mask_q;
endmodule
`default_nettype wire

/* dv/sdes_status_properties.sv */
// Purpose: Port-level checks for the drop-event status register.
// Assumes: Only the top module ports are visible; mask state is mirrored here.
// Notes:   Bound to sdes_status from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_regs.svh"
module sdes_status_properties
   import sdes_pkg::*;
(
   input wire logic                    clk,         // Core clock
   input wire logic                    nrst,        // Reset, active low
   input wire logic                    reg_rd,      // Read strobe
   input wire logic                    reg_wr,      // Write strobe
   input wire sdes_pkg::sdes_reg_num_t reg_num,     // Register number
   input wire logic [31:0]             reg_wdata,   // Write data
   input wire logic [31:0]             reg_rdata,   // Read data
   input wire logic                    reg_rack,    // Read answer
   input wire logic                    check_valid, // Decision strobe
   input wire sdes_pkg::sdes_port_t    src_port,    // Decision source port
   input wire logic                    vid_all_ones,// All-ones VLAN id
   input wire logic                    drop_irq     // Engine interrupt
);
   logic mask_q;
   logic st_q;

   // The mask is mirrored because the checker cannot see inside the design.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= 1'h1;
         st_q   <= 1'h0;
      end else begin
         if (reg_wr && reg_num == `SDES_OFS_IMASK) mask_q <= reg_wdata[0];
         st_q <= reg_rd && reg_num == `SDES_OFS_STATUS;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence read_stat;
      reg_rd && reg_num == `SDES_OFS_STATUS;
   endsequence
   sequence quiet_read;
      reg_rd && reg_num == `SDES_OFS_STATUS && !check_valid;
   endsequence
   sequence vid_drop;
      check_valid && vid_all_ones && src_port != `SDES_PORT_RESERVED;
   endsequence

   rack_follows_a: assert property (reg_rd |=> reg_rack)
      else $error("read strobe not answered");
   rack_cause_a: assert property (reg_rack |-> $past(reg_rd))
      else $error("read answer without read");
   rdata_idle_a: assert property (!reg_rack |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer");
   upper_zero_a: assert property (reg_rack && st_q |-> reg_rdata[31:15] == 17'h0_0000)
      else $error("upper status bits set");
   port_legal_a: assert property (reg_rack && st_q && reg_rdata[1] |-> reg_rdata[3:2] != 2'h3)
      else $error("reserved port code recorded");
   b_after_a_a: assert property (reg_rack && st_q && reg_rdata[8] |-> reg_rdata[1] && reg_rdata[0])
      else $error("record B without record A");
   clear_read_a: assert property (quiet_read ##1 read_stat |=> reg_rdata == 32'h0000_0000)
      else $error("status not cleared by read");
   mask_blocks_a: assert property (mask_q |-> !drop_irq)
      else $error("interrupt while masked");
   unmask_irq_a: assert property (vid_drop ##0 (!mask_q && !reg_wr) |=> drop_irq)
      else $error("unmasked drop gave no interrupt");
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the drop-event status register.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Every reason code is recorded through records A and B in turn.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
   import sdes_pkg::*;
   logic          clk = 1'h0;
   logic          nrst;
   logic          reg_rd;
   logic          reg_wr;
   logic          check_valid;
   logic          drop_irq;
   logic          reg_rack;
   sdes_reg_num_t reg_num;
   logic [31:0]   reg_wdata;
   logic [31:0]   reg_rdata;
   logic [31:0]   e;
   sdes_port_t    src_port;
   logic [16:0]   c;
   int            err_count = 0;
   int            num_checks = 0;
   // Baseline 17'h0_1E00: both ports forwarding and members; each case adds one cause.
   logic [16:0]   cases [13] = '{17'h0_1E03, 17'h0_1C80, 17'h0_1610, 17'h0_0E10, 17'h0_1A90,
      17'h0_1C90, 17'h0_3E20, 17'h0_5E40, 17'h0_1E08, 17'h0_1600, 17'h0_9E10, 17'h1_1E10,
      17'h0_1E04};
   sdes_reason_t  rsn [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
      4'hA, 4'hB, 4'hE};

   sdes_status dut (.clk(clk), .nrst(nrst), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
      .check_valid(check_valid), .src_port(src_port), .tagged_only_admission(c[0]),
      .pkt_untagged(c[1]), .vid_all_ones(c[2]), .bcast_over_limit(c[3]), .da_hit(c[4]),
      .da_unicast(c[5]), .da_multicast(c[6]), .member_check(c[7]),
      .admit_non_member(c[8]), .src_member(c[9]), .dst_member(c[10]),
      .src_forwarding(c[11]), .dst_forwarding(c[12]), .drop_unknown(c[13]),
      .filter_multicast(c[14]), .same_port(c[15]), .entry_filter(c[16]),
      .drop_irq(drop_irq));

   always #2.5 clk = ~clk;

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic drop(input logic [16:0] cc, input sdes_port_t p);
      @(posedge clk) #1;
      c = cc;
      src_port = p;
      check_valid = 1'h1;
      @(posedge clk) #1;
      check_valid = 1'h0;
   endtask

   task automatic wr(input sdes_reg_num_t n, input logic [31:0] d);
      @(posedge clk) #1;
      reg_wr = 1'h1;
      reg_num = n;
      reg_wdata = d;
      @(posedge clk) #1;
      reg_wr = 1'h0;
   endtask

   // With two set the strobe is held so a second, back-to-back read must see zero.
   task automatic rd(input sdes_reg_num_t n, input logic [31:0] ex, input bit two);
      @(posedge clk) #1;
      reg_rd = 1'h1;
      reg_num = n;
      @(posedge clk) #1;
      `CHK("read answer", 1'h1, reg_rack)
      `CHK("read data", ex, reg_rdata)
      if (two) begin
         @(posedge clk) #1;
         `CHK("second read", 32'h0000_0000, reg_rdata)
      end
      reg_rd = 1'h0;
   endtask

   initial begin
      #20000;
      err_count++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      {nrst, reg_rd, reg_wr, check_valid} = 4'h0;
      reg_num = 16'h0000;
      reg_wdata = 32'h0000_0000;
      src_port = 2'h0;
      c = 17'h0_0000;
      repeat (4) @(posedge clk);
      #1 nrst = 1'h1;
      rd(`SDES_OFS_IMASK, 32'h0000_0001, 1'b0);
      rd(`SDES_OFS_STATUS, 32'h0000_0000, 1'b0);
      $display("test reset done");
      for (int i = 0; i < 13; i += 2) begin
         e = {17'h0_0000, 7'h00, rsn[i], 2'(i % 3), 2'h3};
         drop(cases[i], 2'(i % 3));
         if (i < 12) begin
            drop(cases[i + 1], 2'((i + 1) % 3));
            e[14:8] = {rsn[i + 1], 2'((i + 1) % 3), 1'h1};
            drop(17'h0_1E04, 2'h0);
         end
         rd(`SDES_OFS_STATUS, e, 1'b1);
      end
      $display("test reason codes done");
      drop(17'h0_1E04, 2'h3);
      drop(17'h0_1E10, 2'h1);
      wr(`SDES_OFS_STATUS, 32'hFFFF_FFFF);
      rd(`SDES_OFS_STATUS, 32'h0000_0000, 1'b0);
      rd(16'h1882, 32'h0000_0000, 1'b0);
      $display("test refusals done");
      drop(17'h0_1E04, 2'h2);
      `CHK("masked interrupt", 1'h0, drop_irq)
      wr(`SDES_OFS_IMASK, 32'h0000_0000);
      `CHK("unmasked interrupt", 1'h1, drop_irq)
      wr(`SDES_OFS_IMASK, 32'h0000_0001);
      `CHK("remasked interrupt", 1'h0, drop_irq)
      rd(`SDES_OFS_STATUS, 32'h0000_00EB, 1'b0);
      wr(`SDES_OFS_IMASK, 32'h0000_0000);
      drop(17'h0_1E04, 2'h0);
      `CHK("fresh interrupt", 1'h1, drop_irq)
      rd(`SDES_OFS_STATUS, 32'h0000_00E3, 1'b0);
      `CHK("interrupt after clear", 1'h0, drop_irq)
      // A drop taken on the same edge as a clearing read must survive into record A.
      fork
         drop(17'h0_1E04, 2'h1);
         rd(`SDES_OFS_STATUS, 32'h0000_0000, 1'b0);
      join
      `CHK("set over clear", 1'h1, drop_irq)
      rd(`SDES_OFS_STATUS, 32'h0000_00E7, 1'b0);
      $display("test interrupt done");
      report_and_stop();
   end
endmodule

bind sdes_status sdes_status_properties chk (.clk(clk), .nrst(nrst), .reg_rd(reg_rd),
   .reg_wr(reg_wr), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rack(reg_rack), .check_valid(check_valid), .src_port(src_port),
   .vid_all_ones(vid_all_ones), .drop_irq(drop_irq));
`default_nettype wire
